// >>> logic/wdt_core.sv
// two-stage watchdog: down counter, nonmaskable time-out interrupt, reset escalation
// ---------------------------------------------------------------
// How it works
// RULE1: a 32-bit down counter reloads from the interval load register.
// RULE2: once enabled, reaching zero raises the first time-out.
// RULE3: setting the interrupt enable also starts the counter.
// RULE4: after the first time-out the counter reloads and keeps counting.
// RULE5: zero again with interrupt pending and reset enabled asserts system reset.
// RULE6: clearing the interrupt in time reloads the counter, no reset follows.
// RULE7: writing the load value while running loads the counter at once.
// RULE8: writing the load value leaves a pending interrupt untouched.
// RULE9: software clears the interrupt only through the interrupt clear register.
// RULE10: re-enabling the interrupt preloads the counter from the load value.
// RULE11: after the lock register is written, configuration writes are refused.
// RULE12: interrupt and reset generation have separate enable bits.
// RULE13: a software stall bit freezes the counter.
// RULE14: time-out drives a nonmaskable interrupt; escalation drives system reset.
// RULE15: any write to the clear register clears interrupt and reloads counter.
// RULE16: a zero load value raises the time-out interrupt at once.
// RULE17: once interrupt enable is set, control writes are ignored until reset.
// RULE18: any lock write other than the unlock key locks; only the unlock key unlocks.
// RULE19: counts down one per clock when running; hardware reset clears all but load and count, which take LOAD_RESET.
// ---------------------------------------------------------------
`include "wdt_defines.svh"
module wdt_core #(
  parameter logic [31:0] LOAD_RESET = `WDT_LOAD_RST
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // axi4-lite write address and data
  input  wire logic [11:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // axi4-lite read
  input  wire logic [11:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // processor and system
  output logic             nmi_o,
  output logic             sys_reset_o,
  output logic             irq_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] load;
    logic [31:0] count;
    logic        int_en;
    logic        rst_en;
    logic        stall;
    logic        pending;
    logic        locked;
    logic        sys_reset;
  } wdt_core_s;

  wdt_core_s st_reg;
  wdt_core_s st_next;

  wdt_reg_if rif ();

  logic [`WDT_EV_W-1:0] ev;
  logic [`WDT_EV_W-1:0] ev_status;
  logic [`WDT_EV_W-1:0] ev_mask;
  logic                 wr_load;
  logic                 wr_ctrl;
  logic                 wr_iclr;
  logic                 wr_stall;
  logic                 wr_lock;
  logic                 wr_evclr;
  logic                 wr_evmsk;
  logic                 wr_cfg;
  logic                 zero_hit;

  // ---------------------------------------------------------------
  // bus slave and event bank
  // ---------------------------------------------------------------
  wdt_axil_slave u_slave (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .awaddr_i  (s_axi_awaddr_i),
    .awvalid_i (s_axi_awvalid_i),
    .awready_o (s_axi_awready_o),
    .wdata_i   (s_axi_wdata_i),
    .wstrb_i   (s_axi_wstrb_i),
    .wvalid_i  (s_axi_wvalid_i),
    .wready_o  (s_axi_wready_o),
    .bresp_o   (s_axi_bresp_o),
    .bvalid_o  (s_axi_bvalid_o),
    .bready_i  (s_axi_bready_i),
    .araddr_i  (s_axi_araddr_i),
    .arvalid_i (s_axi_arvalid_i),
    .arready_o (s_axi_arready_o),
    .rdata_o   (s_axi_rdata_o),
    .rresp_o   (s_axi_rresp_o),
    .rvalid_o  (s_axi_rvalid_o),
    .rready_i  (s_axi_rready_i),
    .rif       (rif.slave)
  );

  wdt_irq_bank #(
    .W (`WDT_EV_W)
  ) u_irq (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .event_i   (ev),
    .clr_stb_i (wr_evclr),
    .msk_stb_i (wr_evmsk),
    .wdata_i   (rif.wr_data[`WDT_EV_W-1:0]),
    .status_o  (ev_status),
    .mask_o    (ev_mask),
    .irq_o     (irq_o)
  );

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  // lock gates the load, control, clear and stall registers; the lock and event registers stay writable
  assign wr_cfg   = rif.wr_stb && !st_reg.locked;
  assign wr_load  = wr_cfg && rif.wr_addr == `WDT_OFF_LOAD;
  assign wr_ctrl  = wr_cfg && rif.wr_addr == `WDT_OFF_CTRL;
  assign wr_iclr  = wr_cfg && rif.wr_addr == `WDT_OFF_ICLR;
  assign wr_stall = wr_cfg && rif.wr_addr == `WDT_OFF_STALL;
  assign wr_lock  = rif.wr_stb && rif.wr_addr == `WDT_OFF_LOCK;
  assign wr_evclr = rif.wr_stb && rif.wr_addr == `WDT_OFF_IRQ_ST;
  assign wr_evmsk = rif.wr_stb && rif.wr_addr == `WDT_OFF_IRQ_MSK;
  assign zero_hit = st_reg.int_en && !st_reg.stall && st_reg.count == 32'h00000000;

  // unmapped writes answer slverr; locked writes are silently dropped
  always_comb begin
    rif.wr_ok = 1'b1;
    if (rif.wr_addr == `WDT_OFF_LOAD || rif.wr_addr == `WDT_OFF_CTRL) begin
      rif.wr_ok = 1'b1;
    end else if (rif.wr_addr == `WDT_OFF_ICLR || rif.wr_addr == `WDT_OFF_STALL) begin
      rif.wr_ok = 1'b1;
    end else if (rif.wr_addr == `WDT_OFF_LOCK || rif.wr_addr == `WDT_OFF_IRQ_ST) begin
      rif.wr_ok = 1'b1;
    end else if (rif.wr_addr == `WDT_OFF_IRQ_MSK) begin
      rif.wr_ok = 1'b1;
    end else begin
      rif.wr_ok = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  always_comb begin
    rif.rd_data = 32'h00000000;
    rif.rd_ok   = 1'b1;
    if (rif.rd_addr == `WDT_OFF_LOAD) begin
      rif.rd_data = st_reg.load;
    end else if (rif.rd_addr == `WDT_OFF_VALUE) begin
      rif.rd_data = st_reg.count;
    end else if (rif.rd_addr == `WDT_OFF_CTRL) begin
      rif.rd_data[`WDT_CTRL_TIMEOUT_INTERRUPT_ENABLE] = st_reg.int_en;
      rif.rd_data[`WDT_CTRL_RESET_OUTPUT_ENABLE] = st_reg.rst_en;
    end else if (rif.rd_addr == `WDT_OFF_ICLR) begin
      rif.rd_data = 32'h00000000;
    end else if (rif.rd_addr == `WDT_OFF_RIS) begin
      rif.rd_data[0] = st_reg.pending;
    end else if (rif.rd_addr == `WDT_OFF_MIS) begin
      rif.rd_data[0] = st_reg.pending && st_reg.int_en;
    end else if (rif.rd_addr == `WDT_OFF_STALL) begin
      rif.rd_data[`WDT_STALL_BIT] = st_reg.stall;
    end else if (rif.rd_addr == `WDT_OFF_LOCK) begin
      rif.rd_data[0] = st_reg.locked;
    end else if (rif.rd_addr == `WDT_OFF_IRQ_ST) begin
      rif.rd_data[`WDT_EV_W-1:0] = ev_status;
    end else if (rif.rd_addr == `WDT_OFF_IRQ_MSK) begin
      rif.rd_data[`WDT_EV_W-1:0] = ev_mask;
    end else begin
      rif.rd_ok = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // counter and escalation
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    ev      = '0;
    // RULE19: decrement per clock
    // RULE13: stall freezes count
    if (st_reg.int_en && !st_reg.stall && st_reg.count != 32'h00000000) begin
      st_next.count = st_reg.count - 32'h00000001;
    end
    // RULE2: zero gives time-out
    // RULE4: reload after time-out
    if (zero_hit) begin
      st_next.count = st_reg.load;
      if (!st_reg.pending) begin
        st_next.pending = 1'b1;
        ev[`WDT_EV_TIMEOUT] = 1'b1;
      end else if (st_reg.rst_en) begin
        // RULE5: second time-out resets
        st_next.sys_reset = 1'b1;
        ev[`WDT_EV_RESET] = 1'b1;
      end
    end
    // RULE7: load write restarts count
    // RULE8: pending kept on load
    if (wr_load) begin
      st_next.load  = rif.wr_data;
      st_next.count = rif.wr_data;
      // RULE16: zero load fires now
      if (rif.wr_data == 32'h00000000 && st_reg.int_en) begin
        st_next.pending = 1'b1;
        ev[`WDT_EV_TIMEOUT] = 1'b1;
      end
    end
    // RULE15: clear and reload
    // RULE6: cleared in time
    // RULE9: only clear register
    if (wr_iclr) begin
      st_next.pending = ev[`WDT_EV_TIMEOUT]; // a time-out in this same cycle wins
      st_next.count   = st_reg.load;
    end
    // RULE17: control frozen once enabled
    // RULE12: separate enables
    // RULE3: enable starts counting
    // RULE10: preload on enable
    if (wr_ctrl && !st_reg.int_en) begin
      st_next.rst_en = rif.wr_data[`WDT_CTRL_RESET_OUTPUT_ENABLE];
      st_next.int_en = rif.wr_data[`WDT_CTRL_TIMEOUT_INTERRUPT_ENABLE];
      if (rif.wr_data[`WDT_CTRL_TIMEOUT_INTERRUPT_ENABLE]) begin
        st_next.count = st_reg.load;
      end
    end
    if (wr_stall) begin
      st_next.stall = rif.wr_data[`WDT_STALL_BIT];
    end
    // RULE18: lock and unlock key
    // RULE11: lock protects config
    if (wr_lock) begin
      st_next.locked = rif.wr_data != `WDT_UNLOCK_KEY;
      ev[`WDT_EV_LOCKWR] = 1'b1;
    end
  end

  // state register; hardware reset restores everything
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg       <= '0;
      st_reg.load  <= LOAD_RESET;
      st_reg.count <= LOAD_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // RULE14: nmi and system reset
  // interrupt is nonmaskable: enable only gates counting, never this output
  assign nmi_o       = st_reg.pending;
  assign sys_reset_o = st_reg.sys_reset;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_first_to;
    zero_hit && !st_reg.pending;
  endsequence

  sequence s_second_to;
    zero_hit && st_reg.pending && st_reg.rst_en && !wr_iclr;
  endsequence

  AST_FIRST_NMI: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE2
    s_first_to |=> nmi_o)
    else $error("first time-out did not raise nmi");
  AST_RELOAD: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE4
    (zero_hit && !wr_load && !wr_iclr && !wr_ctrl) |=> st_reg.count == $past(st_reg.load))
    else $error("counter not reloaded after time-out");
  AST_ESCALATE: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE5
    s_second_to |=> sys_reset_o)
    else $error("second time-out did not reset");
  AST_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE15
    wr_iclr && !zero_hit |=> !nmi_o && st_reg.count == $past(st_reg.load))
    else $error("clear did not drop nmi or reload");
  AST_LOAD_NOW: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE7
    wr_load && !wr_iclr && !wr_ctrl |=> st_reg.count == $past(rif.wr_data))
    else $error("load write not taken into counter");
  AST_LOAD_KEEPS: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE8
    wr_load && nmi_o && !wr_iclr |=> nmi_o)
    else $error("load write cleared nmi");
  AST_CTRL_FROZEN: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE17
    st_reg.int_en |=> st_reg.int_en && st_reg.rst_en == $past(st_reg.rst_en))
    else $error("control changed after enable");
  AST_LOCKED: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE11
    st_reg.locked && rif.wr_stb && rif.wr_addr == `WDT_OFF_LOAD |=>
      st_reg.load == $past(st_reg.load))
    else $error("locked load register changed");
  AST_STALL: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE13
    (st_reg.stall && !rif.wr_stb) [*2] |-> st_reg.count == $past(st_reg.count))
    else $error("counter moved while stalled");
  AST_DECR: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE19
    st_reg.int_en && !st_reg.stall && st_reg.count > 32'h1 && !rif.wr_stb |=>
      st_reg.count == $past(st_reg.count) - 32'h1)
    else $error("counter did not step by one");
endmodule : wdt_core

// >>> logic/wdt_defines.svh
// register offsets, reset values and field positions of the two-stage watchdog
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define WDT_OFF_LOAD    12'h000
`define WDT_OFF_VALUE   12'h004
`define WDT_OFF_CTRL    12'h008
`define WDT_OFF_ICLR    12'h00c
`define WDT_OFF_RIS     12'h010
`define WDT_OFF_MIS     12'h014
`define WDT_OFF_STALL   12'h418
`define WDT_OFF_IRQ_ST  12'h500
`define WDT_OFF_IRQ_MSK 12'h504
`define WDT_OFF_LOCK    12'hc00

// ---------------------------------------------------------------
// reset values, keys and field positions
// ---------------------------------------------------------------
`define WDT_LOAD_RST    32'hffffffff
`define WDT_UNLOCK_KEY  32'h1acce551
`define WDT_CTRL_TIMEOUT_INTERRUPT_ENABLE  0
`define WDT_CTRL_RESET_OUTPUT_ENABLE  1
`define WDT_STALL_BIT   8
`define WDT_EV_TIMEOUT  0
`define WDT_EV_RESET    1
`define WDT_EV_LOCKWR   2
`define WDT_EV_W        3
`define WDT_RESP_OKAY   2'b00
`define WDT_RESP_SLVERR 2'b10

`endif

// >>> logic/wdt_pkg.sv
// types shared by the two-stage watchdog modules
package wdt_pkg;
  // slave channel states
  typedef enum logic [1:0] {
    WDT_BUS_IDLE,
    WDT_BUS_RESP
  } wdt_bus_e;
endpackage : wdt_pkg

// >>> logic/wdt_reg_if.sv
// interface carrying decoded register accesses from the bus slave to the core
interface wdt_reg_if;
  logic        wr_stb;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        wr_ok;

  modport slave (output wr_stb, output wr_addr, output wr_data, output rd_addr,
                 input rd_data, input rd_ok, input wr_ok);
  modport core  (input wr_stb, input wr_addr, input wr_data, input rd_addr,
                 output rd_data, output rd_ok, output wr_ok);
endinterface : wdt_reg_if

// >>> logic/wdt_axil_slave.sv
// axi4-lite slave turning bus transfers into register strobes
`include "wdt_defines.svh"
module wdt_axil_slave (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // write channels
  input  wire logic [11:0] awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  // read channels
  input  wire logic [11:0] araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  // core side
  wdt_reg_if.slave         rif
);
  typedef struct packed {
    logic              aw_got;
    logic              w_got;
    logic [11:0]       awaddr;
    logic [31:0]       wdata;
    wdt_pkg::wdt_bus_e wst;
    logic [1:0]        bresp;
    wdt_pkg::wdt_bus_e rst;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } wdt_axs_s;

  wdt_axs_s st_reg;
  wdt_axs_s st_next;

  // write fires once both halves are held; strobes then pass to the core
  always_comb begin
    st_next       = st_reg;
    rif.wr_stb    = 1'b0;
    rif.wr_addr   = st_reg.awaddr;
    rif.wr_data   = st_reg.wdata;
    rif.rd_addr   = araddr_i;
    if (awvalid_i && !st_reg.aw_got && st_reg.wst == wdt_pkg::WDT_BUS_IDLE) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = awaddr_i;
    end
    if (wvalid_i && !st_reg.w_got && st_reg.wst == wdt_pkg::WDT_BUS_IDLE) begin
      st_next.w_got = 1'b1;
      // partial strobes still write the whole word; the registers are word-only
      st_next.wdata = wdata_i;
    end
    case (st_reg.wst)
      wdt_pkg::WDT_BUS_IDLE: begin
        if (st_reg.aw_got && st_reg.w_got) begin
          rif.wr_stb    = 1'b1;
          st_next.bresp = rif.wr_ok ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
          st_next.wst   = wdt_pkg::WDT_BUS_RESP;
        end
      end
      default: begin
        if (bready_i) begin
          st_next.wst    = wdt_pkg::WDT_BUS_IDLE;
          st_next.aw_got = 1'b0;
          st_next.w_got  = 1'b0;
        end
      end
    endcase
    // reads answer one cycle after the address is taken
    case (st_reg.rst)
      wdt_pkg::WDT_BUS_IDLE: begin
        if (arvalid_i) begin
          st_next.rdata = rif.rd_data;
          st_next.rresp = rif.rd_ok ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
          st_next.rst   = wdt_pkg::WDT_BUS_RESP;
        end
      end
      default: begin
        if (rready_i) begin
          st_next.rst = wdt_pkg::WDT_BUS_IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg <= '{default: '0, wst: wdt_pkg::WDT_BUS_IDLE, rst: wdt_pkg::WDT_BUS_IDLE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign awready_o = !st_reg.aw_got && st_reg.wst == wdt_pkg::WDT_BUS_IDLE;
  assign wready_o  = !st_reg.w_got && st_reg.wst == wdt_pkg::WDT_BUS_IDLE;
  assign bvalid_o  = st_reg.wst == wdt_pkg::WDT_BUS_RESP;
  assign bresp_o   = st_reg.bresp;
  assign arready_o = st_reg.rst == wdt_pkg::WDT_BUS_IDLE;
  assign rvalid_o  = st_reg.rst == wdt_pkg::WDT_BUS_RESP;
  assign rdata_o   = st_reg.rdata;
  assign rresp_o   = st_reg.rresp;

  // a response never appears without a taken write
  AST_B_AFTER_W: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(bvalid_o) |-> $past(st_reg.aw_got && st_reg.w_got))
    else $error("write response without both halves");
endmodule : wdt_axil_slave

// >>> logic/wdt_irq_bank.sv
// sticky event bits with write-one-to-clear, mask and one level interrupt
`include "wdt_defines.svh"
module wdt_irq_bank #(
  parameter int W = `WDT_EV_W
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  // events and software access
  input  wire logic [W-1:0] event_i,
  input  wire logic         clr_stb_i,
  input  wire logic         msk_stb_i,
  input  wire logic [W-1:0] wdata_i,
  // state
  output logic [W-1:0]      status_o,
  output logic [W-1:0]      mask_o,
  output logic              irq_o
);
  typedef struct packed {
    logic [W-1:0] status;
    logic [W-1:0] mask;
    logic         irq;
  } wdt_irq_s;

  wdt_irq_s st_reg;
  wdt_irq_s st_next;

  // set wins over a clear in the same cycle
  always_comb begin
    st_next        = st_reg;
    st_next.status = (st_reg.status & ~(clr_stb_i ? wdata_i : '0)) | event_i;
    if (msk_stb_i) begin
      st_next.mask = wdata_i;
    end
    st_next.irq = |(st_next.status & st_next.mask);
  end

  // state register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign status_o = st_reg.status;
  assign mask_o   = st_reg.mask;
  assign irq_o    = st_reg.irq;

  // an event is never lost, even against a clear
  AST_EVENT_STICKS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    |event_i |=> ((status_o & $past(event_i)) == $past(event_i)))
    else $error("event bit not held");
endmodule : wdt_irq_bank

// >>> test/wdt_sys_model.sv
// system side model: processor nmi input and system reset logic
module wdt_sys_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // watchdog outputs
  input  wire logic nmi_i,
  input  wire logic sys_reset_i,
  // observed state
  output logic      nmi_seen_o,
  output logic      rst_seen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // no mask input here: the processor cannot ignore this interrupt
  // nmi and reset
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      nmi_seen_o <= 1'b0;
      rst_seen_o <= 1'b0;
    end else begin
      nmi_seen_o <= nmi_seen_o | nmi_i;
      rst_seen_o <= rst_seen_o | sys_reset_i;
    end
  end
endmodule : wdt_sys_model

// >>> test/wdt_core_tb.sv
// self-checking bench for the two-stage watchdog core
`include "wdt_defines.svh"
module wdt_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, sys_rst_i, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
  logic        nmi_o, sys_reset_o, irq_o, rst_seen, m_nmi, m_lock, m_stall;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, rnd, m_load, got;
  logic [1:0]  bresp, rresp, rsp, m_ctrl;
  int          failures, compares;
  wdt_core DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
    .nmi_o(nmi_o), .sys_reset_o(sys_reset_o), .irq_o(irq_o));
  wdt_sys_model u_sys (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .nmi_i(nmi_o),
    .sys_reset_i(sys_reset_o), .nmi_seen_o(), .rst_seen_o(rst_seen));
  // free-running 125 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // watchdog: whole run is several hundred cycles
  initial begin
    #100us;
    failures++;
    final_report();
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // outputs sampled at the falling edge, away from register updates
  task automatic chk_out(input string n, input logic e, input int sel);
    logic g;
    @(negedge clk_i);
    g = (sel == 0) ? nmi_o : (sel == 1) ? sys_reset_o : (sel == 2) ? irq_o : rst_seen;
    chk(n, {31'h0, e}, {31'h0, g});
  endtask : chk_out
  // ready seen at the falling edge equals what the next rising edge samples
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge clk_i);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    while (!tb) begin
      @(negedge clk_i);
      ta = awv & awr;
      tw = wv & wr_r;
      tb = bv & br;
      r  = bresp;
      @(posedge clk_i);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    br <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    tr = 1'b0;
    @(posedge clk_i);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    while (!tr) begin
      @(negedge clk_i);
      ta = arv & arr;
      tr = rv & rr;
      d  = rdat;
      r  = rresp;
      @(posedge clk_i);
      if (ta) arv <= 1'b0;
    end
    rr <= 1'b0;
  endtask : axi_rd
  function automatic logic mapped(input logic [11:0] a);
    return a inside {`WDT_OFF_LOAD, `WDT_OFF_VALUE, `WDT_OFF_CTRL, `WDT_OFF_ICLR, `WDT_OFF_RIS,
      `WDT_OFF_MIS, `WDT_OFF_STALL, `WDT_OFF_IRQ_ST, `WDT_OFF_IRQ_MSK, `WDT_OFF_LOCK};
  endfunction : mapped
  // write with the behavioural register model following it
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    axi_wr(a, d, rsp);
    chk("bresp", {30'h0, mapped(a) ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR}, {30'h0, rsp});
    if (!m_lock && a == `WDT_OFF_LOAD) m_load = d;
    if (!m_lock && a == `WDT_OFF_CTRL && !m_ctrl[0]) m_ctrl = d[1:0];
    if (!m_lock && a == `WDT_OFF_ICLR) m_nmi = 1'b0;
    if (!m_lock && a == `WDT_OFF_STALL) m_stall = d[`WDT_STALL_BIT];
    if (a == `WDT_OFF_LOCK) m_lock = (d !== `WDT_UNLOCK_KEY);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a);
    logic [31:0] e;
    case (a)
      `WDT_OFF_LOAD:  e = m_load;
      `WDT_OFF_CTRL:  e = {30'h0, m_ctrl};
      `WDT_OFF_RIS:   e = {31'h0, m_nmi};
      `WDT_OFF_MIS:   e = {31'h0, m_nmi & m_ctrl[0]};
      `WDT_OFF_STALL: e = {23'h0, m_stall, 8'h0};
      default:        e = {31'h0, m_lock};
    endcase
    axi_rd(a, got, rsp);
    chk("rresp", {30'h0, mapped(a) ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR}, {30'h0, rsp});
    if (mapped(a)) chk("rdata", e, got);
  endtask : rd_chk
  task automatic wait_hi(input int sel, input int lim);
    int n;
    n = 0;
    while ((sel ? sys_reset_o : nmi_o) !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_hi
  task automatic hw_reset(input int n);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    {m_load, m_ctrl, m_nmi, m_lock, m_stall} = {`WDT_LOAD_RST, 5'h0};
  endtask : hw_reset
  task automatic final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    {sys_rst_i, awv, wv, br, arv, rr, awa, ara, wd} = {1'b1, 5'h0, 24'h0, 32'h0};
    {failures, compares, rnd} = {32'h0, 32'h0, 32'hc67a2155};
    hw_reset(20);
    rd_chk(`WDT_OFF_LOAD);
    rd_chk(`WDT_OFF_CTRL);
    rd_chk(`WDT_OFF_LOCK);
    axi_rd(`WDT_OFF_VALUE, got, rsp);
    chk("value", `WDT_LOAD_RST, got);
    wr(12'h100, 32'h0);
    rd_chk(12'h100);
    $display("test reset done");
    rnd = lfsr(rnd);
    wr(`WDT_OFF_LOAD, {26'h0, rnd[5:0]} + 32'h20);
    wr(`WDT_OFF_STALL, 32'h100);
    wr(`WDT_OFF_CTRL, 32'h3);
    repeat (5) @(posedge clk_i);
    axi_rd(`WDT_OFF_VALUE, got, rsp);
    chk("value", m_load, got);
    wr(`WDT_OFF_STALL, 32'h0);
    wait_hi(0, 3 * m_load);
    m_nmi = 1'b1;
    chk_out("nmi", 1'b1, 0);
    rd_chk(`WDT_OFF_MIS);
    wr(`WDT_OFF_CTRL, 32'h0);
    rd_chk(`WDT_OFF_CTRL);
    wr(`WDT_OFF_LOAD, m_load + 32'h40);
    axi_rd(`WDT_OFF_VALUE, got, rsp);
    chk("value", 32'h1, {31'h0, got <= m_load && got + 32'h10 >= m_load});
    rd_chk(`WDT_OFF_RIS);
    rnd = lfsr(rnd);
    wr(`WDT_OFF_ICLR, rnd);
    chk_out("nmi", 1'b0, 0);
    axi_rd(`WDT_OFF_VALUE, got, rsp);
    chk("value", 32'h1, {31'h0, got <= m_load && got + 32'h10 >= m_load});
    wait_hi(0, 2 * m_load + 20);
    m_nmi = 1'b1;
    chk_out("nmi", 1'b1, 0);
    chk_out("sys_reset", 1'b0, 1);
    wait_hi(1, 2 * m_load + 20);
    chk_out("sys_reset", 1'b1, 1);
    chk_out("reset seen", 1'b1, 3);
    axi_rd(`WDT_OFF_IRQ_ST, got, rsp);
    chk("events", 32'h3, got & 32'h3);
    wr(`WDT_OFF_IRQ_MSK, 32'h2);
    chk_out("irq", 1'b1, 2);
    wr(`WDT_OFF_IRQ_MSK, 32'h0);
    chk_out("irq", 1'b0, 2);
    $display("test time-out done");
    hw_reset(2);
    chk_out("sys_reset", 1'b0, 1);
    rnd = lfsr(rnd);
    wr(`WDT_OFF_LOCK, rnd & 32'h0fffffff);
    rd_chk(`WDT_OFF_LOCK);
    wr(`WDT_OFF_LOAD, 32'h77);
    wr(`WDT_OFF_CTRL, 32'h1);
    rd_chk(`WDT_OFF_LOAD);
    rd_chk(`WDT_OFF_CTRL);
    wr(`WDT_OFF_IRQ_MSK, 32'h4);
    chk_out("irq", 1'b1, 2);
    wr(`WDT_OFF_LOCK, `WDT_UNLOCK_KEY);
    wr(`WDT_OFF_IRQ_ST, 32'h4);
    chk_out("irq", 1'b0, 2);
    wr(`WDT_OFF_LOAD, 32'h77);
    rd_chk(`WDT_OFF_LOAD);
    wr(`WDT_OFF_CTRL, 32'h1);
    wr(`WDT_OFF_LOAD, 32'h0);
    wait_hi(0, 8);
    m_nmi = 1'b1;
    chk_out("nmi", 1'b1, 0);
    repeat (20) @(posedge clk_i);
    chk_out("sys_reset", 1'b0, 1);
    $display("test lock done");
    final_report();
  end
endmodule : wdt_core_tb
